// File: hw/ppl_pkg.sv
// Constants, types and helpers shared by the pixel palette lookup block
// How it works
// - At 4 bpp each byte yields two pixels; each nibble indexes entries 0-15.
// - The upper nibble is the left pixel, the lower nibble the next one.
// - At 8 bpp colour each byte is one pixel indexing any of 256 entries.
// - The palette holds 256 entries of 6-bit red, green and blue.
// - Only the low indices the depth allows are used: 2, 4, 16 or 256.
// - Colour modes output the full triple; mono modes output green only.
// - Colour select bit 0 means green-only output, 1 means all components.
// - In 8 bpp mono only the low six index bits count, giving 64 greys.
// - A 16 bpp pixel is red 5 bits high, green 6 middle, blue 5 low.
// - At 16 bpp the palette is bypassed and fields pass straight out.
// - In 16 bpp mono the six green bits alone give the grey level.
// - Write port 0x18: index 31-24, red 23-18, green 15-10, blue 7-2.
// - Staged colour commits to the palette only when the index byte is written.
// - The write port is write-only and reads as zero.
// - Host writes an index to 0x1C bits 31-24, then reads that entry back.
// - The read port index field is write-only and reads as zero.
// - The write port resets to all zeros; the read port index resets to 0, so it returns entry 0.
package ppl_pkg;
  localparam logic [7:0]  PPL_OFF_CTRL   = 8'h0C;
  localparam logic [7:0]  PPL_OFF_WPORT  = 8'h18;
  localparam logic [7:0]  PPL_OFF_RPORT  = 8'h1C;
  localparam logic [31:0] PPL_PORT_RST   = 32'h0000_0000;
  localparam int          PPL_IDX_LSB    = 24;
  localparam int          PPL_RED_LSB    = 18;
  localparam int          PPL_GRN_LSB    = 10;
  localparam int          PPL_BLU_LSB    = 2;
  localparam int          PPL_CHAN_W     = 6;
  localparam int          PPL_CTRL_COLOR = 6;
  localparam int          PPL_PAL_DEPTH  = 256;
  localparam logic [1:0]  PPL_READ_WAIT  = 2'h1;
  localparam logic [2:0]  PPL_DEPTH_1    = 3'h0;
  localparam logic [2:0]  PPL_DEPTH_2    = 3'h1;
  localparam logic [2:0]  PPL_DEPTH_4    = 3'h2;
  localparam logic [2:0]  PPL_DEPTH_8    = 3'h3;
  localparam logic [2:0]  PPL_DEPTH_16   = 3'h4;

  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } ppl_rgb_t;

  typedef struct packed {
    logic     valid;
    logic     mono;
    ppl_rgb_t rgb;
  } ppl_pix_out_t;
endpackage

// File: hw/ppl_palette_ram.sv
// Palette storage: 256 colour entries, one write port, two registered read ports
`timescale 1ns/1ps
module ppl_palette_ram (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             wrEn,
  input  wire logic [7:0]       wrAddr,
  input  wire ppl_pkg::ppl_rgb_t wrData,
  input  wire logic [7:0]       rdAddrA,
  output ppl_pkg::ppl_rgb_t     rdDataA,
  input  wire logic [7:0]       rdAddrB,
  output ppl_pkg::ppl_rgb_t     rdDataB
);
  typedef struct packed {
    ppl_pkg::ppl_rgb_t rdA;
    ppl_pkg::ppl_rgb_t rdB;
  } ppl_ram_state_t;

  ppl_pkg::ppl_rgb_t mem [ppl_pkg::PPL_PAL_DEPTH];
  ppl_ram_state_t    st;
  ppl_ram_state_t    next_st;

  // Read before write: a same-cycle write shows on the following read
  always_comb begin
    next_st.rdA = mem[rdAddrA];
    next_st.rdB = mem[rdAddrB];
  end

  // Contents are not reset; software loads the palette before use
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdDataA = st.rdA;
  assign rdDataB = st.rdB;
endmodule

// File: hw/ppl_pixel_palette_lookup.sv
// Pixel unpacker and palette lookup with an AHB-Lite register slave
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module ppl_pixel_palette_lookup (
  input  wire logic           core_clk,
  input  wire logic           rst_n,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic [31:0]         hrdata,
  output logic                hresp,
  input  wire logic           pixValid,
  input  wire logic [15:0]    pixData,
  output logic                pixReady,
  output ppl_pkg::ppl_pix_out_t pixOut
);
  typedef struct packed {
    logic                  hreadyout;
    logic                  hresp;
    logic [31:0]           hrdata;
    logic                  apValid;
    logic                  apWrite;
    logic [7:0]            apAddr;
    logic [2:0]            apSize;
    logic [1:0]            rdWait;
    logic                  ctrlColor;
    logic [2:0]            ctrlDepth;
    logic [31:0]           staged;
    logic [7:0]            readIndex;
    logic                  pixReady;
    logic [7:0]            shiftByte;
    logic [2:0]            remain;
    logic                  s1Valid;
    logic                  s1Direct;
    logic                  s1Mono;
    ppl_pkg::ppl_rgb_t     s1Rgb;
    ppl_pkg::ppl_pix_out_t pixOut;
  } ppl_top_state_t;

  ppl_top_state_t    st;
  ppl_top_state_t    next_st;
  ppl_pkg::ppl_rgb_t ramDataA;
  ppl_pkg::ppl_rgb_t ramDataB;
  ppl_pkg::ppl_rgb_t ramWData;
  logic [7:0]        ramWAddr;
  logic [7:0]        ramAddrA;
  logic              ramWe;
  logic [3:0]        lanes;
  logic [31:0]       merged;
  logic              accept;
  logic              pixTake;

  function automatic logic [7:0] wordAddr(input logic [7:0] a);
    wordAddr = {a[7:2], 2'b00};
  endfunction

  // Little-endian lanes; byte 3 carries the palette index
  function automatic logic [3:0] laneMask(input logic [2:0] size, input logic [1:0] off);
    case (size)
      3'h0:    laneMask = 4'h1 << off;
      3'h1:    laneMask = off[1] ? 4'hC : 4'h3;
      default: laneMask = 4'hF;
    endcase
  endfunction

  function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] m);
    mergeLanes = old;
    for (int i = 0; i < 4; i++) begin
      if (m[i]) begin
        mergeLanes[8*i +: 8] = wd[8*i +: 8];
      end
    end
  endfunction

  function automatic ppl_pkg::ppl_rgb_t unpackRgb(input logic [31:0] w);
    unpackRgb.red   = w[ppl_pkg::PPL_RED_LSB +: ppl_pkg::PPL_CHAN_W];
    unpackRgb.green = w[ppl_pkg::PPL_GRN_LSB +: ppl_pkg::PPL_CHAN_W];
    unpackRgb.blue  = w[ppl_pkg::PPL_BLU_LSB +: ppl_pkg::PPL_CHAN_W];
  endfunction

  // Index field and unused bits stay zero
  function automatic logic [31:0] packPort(input ppl_pkg::ppl_rgb_t c);
    packPort = ppl_pkg::PPL_PORT_RST;
    packPort[ppl_pkg::PPL_RED_LSB +: ppl_pkg::PPL_CHAN_W] = c.red;
    packPort[ppl_pkg::PPL_GRN_LSB +: ppl_pkg::PPL_CHAN_W] = c.green;
    packPort[ppl_pkg::PPL_BLU_LSB +: ppl_pkg::PPL_CHAN_W] = c.blue;
  endfunction

  function automatic logic [3:0] depthBits(input logic [2:0] d);
    case (d)
      ppl_pkg::PPL_DEPTH_1: depthBits = 4'h1;
      ppl_pkg::PPL_DEPTH_2: depthBits = 4'h2;
      ppl_pkg::PPL_DEPTH_4: depthBits = 4'h4;
      default:              depthBits = 4'h8;
    endcase
  endfunction

  // Leftmost pixel sits in the top bits; indices are zero-extended
  function automatic logic [7:0] pixIndex(input logic [7:0] b, input logic [2:0] d,
                                          input logic mono);
    case (d)
      ppl_pkg::PPL_DEPTH_1: pixIndex = {7'h00, b[7]};
      ppl_pkg::PPL_DEPTH_2: pixIndex = {6'h00, b[7:6]};
      ppl_pkg::PPL_DEPTH_4: pixIndex = {4'h0, b[7:4]};
      default:              pixIndex = mono ? {2'b00, b[5:0]} : b;
    endcase
  endfunction

  function automatic logic [2:0] firstRemain(input logic [2:0] d);
    case (d)
      ppl_pkg::PPL_DEPTH_1: firstRemain = 3'h7;
      ppl_pkg::PPL_DEPTH_2: firstRemain = 3'h3;
      ppl_pkg::PPL_DEPTH_4: firstRemain = 3'h1;
      default:              firstRemain = 3'h0;
    endcase
  endfunction

  ppl_palette_ram u_palette (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wrEn     (ramWe),
    .wrAddr   (ramWAddr),
    .wrData   (ramWData),
    .rdAddrA  (ramAddrA),
    .rdDataA  (ramDataA),
    .rdAddrB  (st.readIndex),
    .rdDataB  (ramDataB)
  );

  always_comb begin
    next_st  = st;
    ramWe    = 1'b0;
    ramWAddr = st.staged[ppl_pkg::PPL_IDX_LSB +: 8];
    ramWData = unpackRgb(st.staged);
    ramAddrA = 8'h00;
    lanes    = laneMask(st.apSize, st.apAddr[1:0]);
    merged   = mergeLanes(st.staged, hwdata, lanes);
    accept   = hsel && htrans[1] && hready;
    pixTake  = pixValid && st.pixReady;

    // Bus data phase
    if (st.apValid && st.apWrite) begin
      next_st.apValid = 1'b0;
      case (wordAddr(st.apAddr))
        ppl_pkg::PPL_OFF_WPORT: begin
          next_st.staged = merged;
          // Partial writes only stage; the index byte completes the entry
          if (lanes[3]) begin
            ramWe    = 1'b1;
            ramWAddr = merged[ppl_pkg::PPL_IDX_LSB +: 8];
            ramWData = unpackRgb(merged);
          end
        end
        ppl_pkg::PPL_OFF_RPORT: begin
          if (lanes[3]) begin
            next_st.readIndex = hwdata[ppl_pkg::PPL_IDX_LSB +: 8];
          end
        end
        ppl_pkg::PPL_OFF_CTRL: begin
          if (lanes[0]) begin
            next_st.ctrlColor = hwdata[ppl_pkg::PPL_CTRL_COLOR];
            next_st.ctrlDepth = hwdata[2:0];
          end
        end
        default: begin
        end
      endcase
    end else if (st.apValid) begin
      // Two wait states let a just-written read index reach the palette
      if (st.rdWait != 2'h0) begin
        next_st.rdWait = st.rdWait - 2'h1;
      end else begin
        next_st.hreadyout = 1'b1;
        next_st.apValid   = 1'b0;
        case (wordAddr(st.apAddr))
          ppl_pkg::PPL_OFF_RPORT: next_st.hrdata = packPort(ramDataB);
          ppl_pkg::PPL_OFF_CTRL: begin
            next_st.hrdata = ppl_pkg::PPL_PORT_RST;
            next_st.hrdata[ppl_pkg::PPL_CTRL_COLOR] = st.ctrlColor;
            next_st.hrdata[2:0] = st.ctrlDepth;
          end
          default: next_st.hrdata = ppl_pkg::PPL_PORT_RST;
        endcase
      end
    end

    if (accept) begin
      next_st.apValid = 1'b1;
      next_st.apWrite = hwrite;
      next_st.apAddr  = haddr[7:0];
      next_st.apSize  = hsize;
      if (!hwrite) begin
        next_st.hreadyout = 1'b0;
        next_st.rdWait    = ppl_pkg::PPL_READ_WAIT;
      end
    end

    // Pixel unpack stage; a depth change mid-byte applies to the rest
    next_st.s1Valid  = 1'b0;
    next_st.s1Direct = 1'b0;
    next_st.s1Mono   = !st.ctrlColor;
    if (pixTake && st.ctrlDepth == ppl_pkg::PPL_DEPTH_16) begin
      next_st.s1Valid   = 1'b1;
      next_st.s1Direct  = 1'b1;
      next_st.s1Rgb.red   = {pixData[15:11], 1'b0};
      next_st.s1Rgb.green = pixData[10:5];
      next_st.s1Rgb.blue  = {pixData[4:0], 1'b0};
    end else if (pixTake) begin
      next_st.s1Valid   = 1'b1;
      ramAddrA          = pixIndex(pixData[7:0], st.ctrlDepth, !st.ctrlColor);
      next_st.shiftByte = pixData[7:0] << depthBits(st.ctrlDepth);
      next_st.remain    = firstRemain(st.ctrlDepth);
    end else if (st.remain != 3'h0) begin
      next_st.s1Valid   = 1'b1;
      ramAddrA          = pixIndex(st.shiftByte, st.ctrlDepth, !st.ctrlColor);
      next_st.shiftByte = st.shiftByte << depthBits(st.ctrlDepth);
      next_st.remain    = st.remain - 3'h1;
    end
    next_st.pixReady = (next_st.remain == 3'h0);

    // Output stage toward the modulator
    next_st.pixOut.valid = st.s1Valid;
    next_st.pixOut.mono  = st.s1Mono;
    next_st.pixOut.rgb   = st.s1Direct ? st.s1Rgb : ramDataA;
    if (st.s1Mono) begin
      next_st.pixOut.rgb.red  = 6'h00;
      next_st.pixOut.rgb.blue = 6'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st           <= '0;
      st.hreadyout <= 1'b1;
      st.pixReady  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = st.hreadyout;
  assign hrdata    = st.hrdata;
  assign hresp     = st.hresp;
  assign pixReady  = st.pixReady;
  assign pixOut    = st.pixOut;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic rdFinal;
  assign rdFinal = st.apValid && !st.apWrite && st.rdWait == 2'h0;

  property p_wportReadsZero;
    rdFinal && wordAddr(st.apAddr) == ppl_pkg::PPL_OFF_WPORT
      |=> hreadyout && hrdata == 32'h0000_0000;
  endproperty
  a_wportReadsZero: assert property (p_wportReadsZero) else $error("write port read not zero");

  property p_rportIndexZero;
    rdFinal && wordAddr(st.apAddr) == ppl_pkg::PPL_OFF_RPORT
      |=> hreadyout && hrdata[31:24] == 8'h00 && hrdata == packPort($past(ramDataB));
  endproperty
  a_rportIndexZero: assert property (p_rportIndexZero) else $error("read port data wrong");

  property p_rportUnused;
    rdFinal && wordAddr(st.apAddr) == ppl_pkg::PPL_OFF_RPORT
      |=> hrdata[17:16] == 2'b00 && hrdata[9:8] == 2'b00 && hrdata[1:0] == 2'b00;
  endproperty
  a_rportUnused: assert property (p_rportUnused) else $error("unused read bits set");

  property p_readWait;
    accept && !hwrite |=> !hreadyout ##1 !hreadyout ##1 hreadyout;
  endproperty
  a_readWait: assert property (p_readWait) else $error("read wait states wrong");

  property p_commitOnIndex;
    ramWe |-> st.apValid && st.apWrite && lanes[3]
              && wordAddr(st.apAddr) == ppl_pkg::PPL_OFF_WPORT;
  endproperty
  a_commitOnIndex: assert property (p_commitOnIndex) else $error("palette commit too early");

  property p_wordWrite;
    st.apValid && st.apWrite && lanes == 4'hF && wordAddr(st.apAddr) == ppl_pkg::PPL_OFF_WPORT
      |-> ramWe && ramWAddr == hwdata[31:24] && ramWData.red == hwdata[23:18]
          && ramWData.green == hwdata[15:10] && ramWData.blue == hwdata[7:2];
  endproperty
  a_wordWrite: assert property (p_wordWrite) else $error("write port fields misplaced");

  property p_fourBpp;
    pixTake && st.ctrlDepth == ppl_pkg::PPL_DEPTH_4 |=> !pixReady && st.s1Valid ##1 pixReady;
  endproperty
  a_fourBpp: assert property (p_fourBpp) else $error("4 bpp byte not split in two");

  property p_latency;
    pixTake |-> ##2 pixOut.valid;
  endproperty
  a_latency: assert property (p_latency) else $error("pixel output latency wrong");

  property p_monoWrap;
    pixTake && st.ctrlDepth == ppl_pkg::PPL_DEPTH_8 && !st.ctrlColor
      |-> ramAddrA == {2'b00, pixData[5:0]};
  endproperty
  a_monoWrap: assert property (p_monoWrap) else $error("8 bpp mono index not wrapped");

  property p_bypass16;
    logic [15:0] d;
    (pixTake && st.ctrlDepth == ppl_pkg::PPL_DEPTH_16 && st.ctrlColor, d = pixData)
      |-> ##2 pixOut.valid && pixOut.rgb.red == {d[15:11], 1'b0}
              && pixOut.rgb.green == d[10:5] && pixOut.rgb.blue == {d[4:0], 1'b0};
  endproperty
  a_bypass16: assert property (p_bypass16) else $error("16 bpp bypass wrong");

  property p_mono16;
    logic [5:0] g;
    (pixTake && st.ctrlDepth == ppl_pkg::PPL_DEPTH_16 && !st.ctrlColor, g = pixData[10:5])
      |-> ##2 pixOut.mono && pixOut.rgb.green == g && pixOut.rgb.red == 6'h00
              && pixOut.rgb.blue == 6'h00;
  endproperty
  a_mono16: assert property (p_mono16) else $error("16 bpp mono grey wrong");

  property p_resetClear;
    @(posedge core_clk) disable iff (1'b0)
      !rst_n |=> hreadyout && hrdata == 32'h0000_0000 && pixReady && !pixOut.valid;
  endproperty
  a_resetClear: assert property (p_resetClear) else $error("reset state wrong");

  c_paletteRead: cover property (rdFinal && wordAddr(st.apAddr) == ppl_pkg::PPL_OFF_RPORT);
  c_paletteCommit: cover property (ramWe);
  c_fourBpp: cover property (pixTake && st.ctrlDepth == ppl_pkg::PPL_DEPTH_4);
  c_bypass16: cover property (pixTake && st.ctrlDepth == ppl_pkg::PPL_DEPTH_16);
endmodule

// File: sim/ppl_fb_model.sv
// Display-buffer side model: offers bytes or pixels and collects panel output
`timescale 1ns/1ps
module ppl_fb_model (
  input  wire logic                  core_clk,
  input  wire logic                  pixReady,
  input  wire ppl_pkg::ppl_pix_out_t pixOut,
  output logic                       pixValid,
  output logic [15:0]                pixData
);
  ppl_pkg::ppl_pix_out_t got [$];
  logic                  timedOut;

  initial begin
    pixValid = 1'b0;
    pixData  = 16'h0000;
    timedOut = 1'b0;
  end

  // Hold the unit until it is taken at an edge with pixReady high
  task automatic send(input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    pixValid <= 1'b1;
    pixData  <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (pixReady !== 1'b1 && n < 50);
    if (n >= 50) timedOut = 1'b1;
    pixValid <= 1'b0;
    // Released data is inverted so a late sample cannot match by chance
    pixData  <= ~d;
  endtask

  // Output stands one cycle per pixel, so collect it at every edge
  always @(posedge core_clk) begin
    if (pixOut.valid === 1'b1) got.push_back(pixOut);
  end
endmodule

// File: sim/tb_ppl_pixel_palette_lookup.sv
// Self-checking bench for the pixel palette lookup block
`timescale 1ns/1ps
module tb_ppl_pixel_palette_lookup;
  logic                  core_clk;
  logic                  rst_n;
  logic                  hsel;
  logic                  hwrite;
  logic                  hreadyout;
  logic                  hresp;
  logic                  pixValid;
  logic                  pixReady;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           haddr;
  logic [31:0]           hwdata;
  logic [31:0]           hrdata;
  logic [15:0]           pixData;
  ppl_pkg::ppl_pix_out_t pixOut;
  int                    errors;
  int                    n_tests;

  ppl_pixel_palette_lookup i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .pixValid(pixValid), .pixData(pixData), .pixReady(pixReady), .pixOut(pixOut)
  );

  ppl_fb_model i_src (
    .core_clk(core_clk), .pixReady(pixReady), .pixOut(pixOut),
    .pixValid(pixValid), .pixData(pixData)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("Mismatches %0d in %0d checks", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic fail(input string what);
    errors++;
    $display("CHECK FAILED at %0t: %s", $time, what);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Single transfer; waits for hready at both phases, data taken at the last edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= sz;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin
      fail("bus wait ran out");
      close_out();
    end
    chk({31'h0000_0000, hresp}, 32'h0000_0000, "response");
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, 3'h2, d, x);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    ahb(1'b0, a, 3'h2, 32'h0000_0000, r);
  endtask

  function automatic ppl_pkg::ppl_rgb_t ent(input int i);
    logic [7:0] b;
    b = i[7:0];
    return '{red: b[5:0], green: b[7:2] ^ 6'h15, blue: ~b[5:0]};
  endfunction

  function automatic logic [31:0] pword(input logic [7:0] top, input int i,
                                        input logic [1:0] f);
    ppl_pkg::ppl_rgb_t e;
    e = ent(i);
    return {top, e.red, f, e.green, f, e.blue, f};
  endfunction

  // Palette is loaded before the read port is read: an unwritten entry is unknown.
  // Unused bits are written as ones and must come back as zero.
  task automatic t_reset();
    logic [31:0] r;
    rd(32'h0000_0018, r);
    chk(r, ppl_pkg::PPL_PORT_RST, "write port at reset");
    for (int i = 0; i < 256; i++) wr(32'h0000_0018, pword(i[7:0], i, 2'b11));
    rd(32'h0000_001C, r);
    chk({24'h00_0000, r[31:24]}, 32'h0000_0000, "read index at reset");
    chk(r, pword(8'h00, 0, 2'b00), "entry at reset index");
  endtask

  task automatic t_palette();
    logic [31:0] r;
    rd(32'h0000_0018, r);
    chk(r, 32'h0000_0000, "write port read");
    for (int i = 0; i < 256; i++) begin
      wr(32'h0000_001C, {i[7:0], 24'hFF_FFFF});
      rd(32'h0000_001C, r);
      chk(r, pword(8'h00, i, 2'b00), "palette readback");
    end
  endtask

  task automatic t_partial();
    logic [31:0] r;
    logic [31:0] nw;
    nw = 32'h10FC_04A8;
    for (int l = 0; l < 3; l++) ahb(1'b1, 32'h0000_0018 + l, 3'h0, nw, r);
    wr(32'h0000_001C, 32'h1000_0000);
    rd(32'h0000_001C, r);
    chk(r, pword(8'h00, 16, 2'b00), "entry before index byte");
    ahb(1'b1, 32'h0000_001B, 3'h0, nw, r);
    rd(32'h0000_001C, r);
    chk(r, {8'h00, nw[23:0]}, "entry after index byte");
    wr(32'h0000_0018, pword(8'h10, 16, 2'b00));
  endtask

  task automatic t_unmapped();
    logic [31:0] r;
    rd(32'h0000_0030, r);
    chk(r, 32'h0000_0000, "unmapped read");
  endtask

  // Expected pixels are derived from the depth, the packing and the palette formula
  task automatic pix(input logic [7:0] ctrl, input logic [15:0] d);
    int                    bpp;
    int                    np;
    int                    idx;
    int                    busy;
    ppl_pkg::ppl_pix_out_t o;
    ppl_pkg::ppl_pix_out_t x;
    wr(32'h0000_000C, {24'h00_0000, ctrl});
    bpp = (ctrl[2:0] == ppl_pkg::PPL_DEPTH_16) ? 16 : 1 << ctrl[2:0];
    np = (bpp >= 8) ? 1 : 8 / bpp;
    i_src.got.delete();
    i_src.send(d);
    if (i_src.timedOut) begin
      fail("pixel not taken");
      close_out();
    end
    // Ready must stay low while the byte still has pixels to emit
    busy = 0;
    for (int n = 0; n < 50 && i_src.got.size() < np; n++) begin
      @(posedge core_clk);
      if (pixReady !== 1'b1) busy++;
    end
    if (i_src.got.size() < np) begin
      fail("pixel wait ran out");
      close_out();
    end
    chk(i_src.got.size(), np, "pixel count");
    chk(busy, np - 1, "busy cycles");
    for (int k = 0; k < np && i_src.got.size() > 0; k++) begin
      x.valid = 1'b1;
      x.mono = ~ctrl[6];
      if (bpp == 16) begin
        x.rgb = '{red: {d[15:11], 1'b0}, green: d[10:5], blue: {d[4:0], 1'b0}};
      end else begin
        idx = (d[7:0] >> (8 - bpp * (k + 1))) & ((1 << bpp) - 1);
        if (bpp == 8 && !ctrl[6]) idx = idx & 63;
        x.rgb = ent(idx);
      end
      if (!ctrl[6]) begin
        x.rgb.red = 6'h00;
        x.rgb.blue = 6'h00;
      end
      o = i_src.got.pop_front();
      chk({12'h000, o}, {12'h000, x}, "pixel");
    end
  endtask

  task automatic t_low_depth();
    pix(8'h40, 16'h00A5);
    pix(8'h41, 16'h001B);
    pix(8'h42, 16'h00AB);
    pix(8'h02, 16'h003C);
    pix(8'h00, 16'h0055);
  endtask

  task automatic t_eight();
    pix(8'h43, 16'h00C5);
    pix(8'h03, 16'h0041);
    pix(8'h03, 16'h00FF);
  endtask

  task automatic t_sixteen();
    pix(8'h44, 16'hA5C3);
    pix(8'h04, 16'hA5C3);
  endtask

  initial begin
    errors = 0;
    n_tests = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_palette();
    t_partial();
    t_unmapped();
    t_low_depth();
    t_eight();
    t_sixteen();
    close_out();
  end
endmodule
